// ==== umb_map.svh ====
// register indices, field positions, codes and counts for the uart
`ifndef UMB_MAP_SVH
`define UMB_MAP_SVH
`define UMB_IX_TXB 24'hFFFE40
`define UMB_IX_RXB 24'hFFFE42
`define UMB_IX_ICT 24'hFFFE44
`define UMB_IX_STA 24'hFFFE46
`define UMB_IX_FRS 24'hFFFE48
`define UMB_IX_MD1 24'hFFFE4A
`define UMB_IX_BDL 24'hFFFE4C
`define UMB_IX_PSR 24'hFFFE4E
`define UMB_IX_OVR 24'hFFFE50
`define UMB_IX_MD2 24'hFFFE52
`define UMB_IX_SPS 24'hFFFE54
// frame select fields
`define UMB_F_CHAR 1:0
`define UMB_F_STP 2
`define UMB_F_XB9 3
`define UMB_F_PSEL 5:4
`define UMB_F_PARITY 6
`define UMB_F_MASK 8'h7F
// mode select one fields
`define UMB_M_ATN 1
`define UMB_M_ERD 2
`define UMB_M_FCE 3
`define UMB_M_RTS 4
`define UMB_M_BRK 5
`define UMB_M_ETD 7
// interrupt control enables
`define UMB_I_ETI 0
`define UMB_I_ERI 1
`define UMB_I_EEI 2
`define UMB_I_EFC 3
// prescaler register fields
`define UMB_P_PSC 7:3
`define UMB_P_DIV 2:0
// character format and parity codes
`define UMB_CH8 2'h0
`define UMB_CH7 2'h1
`define UMB_CH9 2'h2
`define UMB_CHLB 2'h3
`define UMB_PODD 2'h0
`define UMB_PEVEN 2'h1
`define UMB_PMARK 2'h2
`define UMB_PSPACE 2'h3
// oversampling and break counts
`define UMB_OSR 16
`define UMB_SUB_LAST 4'hF
`define UMB_SMP_A 4'h7
`define UMB_SMP_B 4'h8
`define UMB_SMP_C 4'h9
`define UMB_BRK_BITS 10
`define UMB_BRK_TICKS 9'(`UMB_BRK_BITS * `UMB_OSR)
// reset values
`define UMB_RST_TXE 1'b1
`define UMB_RST_LINE 1'b1
`endif

// ==== umb_pkg.sv ====
// types shared by the uart: states, carriers and the state record
package umb_pkg;
  typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} umb_tx_type;
  typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP, R_BRK} umb_rx_type;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [25:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } umb_wb_type;
  typedef struct packed {
    logic tx;
    logic rx;
    logic err;
    logic flow;
  } umb_irq_type;
  typedef struct packed {
    logic tx;
    logic rx;
  } umb_dma_type;
  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    logic [7:0]  tx_data_buffer, rx_data_buffer, frame_select, mode_select_one;
    logic [7:0]  baud_divisor_low, baud_prescaler, oversample_rate, mode_select_two, sample_position;
    logic [3:0]  interrupt_control;
    logic        tx_empty_flag, rx_full_flag, rx_ninth_bit, pe, fe, doe;
    logic        error_summary_flag, bkd, cts_change_flag, cts_q, txd, rts_n;
    umb_irq_type irq;
    umb_dma_type dma;
    logic [5:0]  pacc;
    logic [10:0] dcnt;
    umb_tx_type  txs;
    logic [8:0]  tx_shift_reg;
    logic [3:0]  tsub, tbit;
    logic        tpar;
    umb_rx_type  rxs;
    logic [8:0]  rx_shift_reg;
    logic [3:0]  rsub, rbit;
    logic [1:0]  rsmp;
    logic        rpar;
    logic [8:0]  brkc;
  } umb_st_type;
endpackage

// ==== umb_uart.sv ====
// uart with address wake, loopback, fractional baud, irq and dma requests
// Summary of operation
// - address wake only in nine-bit, no parity
// - ninth bit one marks address, zero data
// - wake mode drops characters until address arrives
// - accepting address clears wake enable bit
// - ninth bit sent from frame select, read in status
// - loopback feeds transmit line into receiver
// - loopback uses nine-bit format without parity
// - start, data lsb first, parity, stop bits
// - nine-bit frames: byte plus ninth, no parity
// - baud from prescaler then eleven-bit divisor
// - prescaler code n divides by (n+1)/2
// - prescaler code zero stops the uart clock
// - tx irq while empty and enabled
// - rx irq while full and enabled
// - error irq; status read clears summary flag
// - flow irq; control read clears change flag
// - tx dma pulse on empty rise, no irq
// - rx dma pulse on full rise, no irq
// - break bit holds transmit line low
// - break reported ten low bit times after a low stop bit
// - parity only for seven/eight-bit, selectable treatment
// - sixteen ticks per bit, three-sample majority
// - divisor stage divides by value plus one
// - format codes eight, seven, nine, loopback
`include "umb_map.svh"
module umb_uart (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  input  umb_pkg::umb_wb_type wb_i,
  output logic               wb_ack_o,
  output logic [31:0]        wb_dat_o,
  input  wire logic          rxd_i,
  input  wire logic          cts_n_i,
  output logic               txd_o,
  output logic               rts_n_o,
  output umb_pkg::umb_irq_type irq_o,
  output umb_pkg::umb_dma_type dma_o
);
  import umb_pkg::*;

  umb_st_type  s;
  umb_st_type  n;
  logic        acc;
  logic        wr;
  logic        rd;
  logic [23:0] ix;
  logic        wr_txb;
  logic        wr_md1;
  logic        rd_rxb;
  logic [4:0]  psc;
  logic [10:0] div;
  logic [5:0]  pnxt;
  logic [5:0]  plim;
  logic        ptick;
  logic        stick;
  logic [1:0]  chr;
  logic        nine;
  logic        par_on;
  logic        atn_act;
  logic        rin;
  logic        v;
  logic [3:0]  nlast;
  logic [7:0]  rbyte;
  logic        rb9;
  logic        dlv;
  logic        xmip;
  logic        line;

  // parity of a character under the selected treatment
  function automatic logic par_f(input logic [7:0] d, input logic [1:0] sel);
    case (sel)
      `UMB_PODD:  par_f = ~^d;
      `UMB_PEVEN: par_f = ^d;
      `UMB_PMARK: par_f = 1'b1;
      default:    par_f = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  assign acc = wb_i.cyc & wb_i.stb & ~s.ack;
  assign wr = acc & wb_i.we & wb_i.sel[0];
  assign rd = acc & ~wb_i.we;
  assign ix = wb_i.adr[25:2];
  assign wr_txb = wr & (ix == `UMB_IX_TXB);
  assign wr_md1 = wr & (ix == `UMB_IX_MD1);
  assign rd_rxb = rd & (ix == `UMB_IX_RXB);

  // baud chain: half-step accumulator then divisor counter
  assign psc = s.baud_prescaler[`UMB_P_PSC];
  assign div = {s.baud_prescaler[`UMB_P_DIV], s.baud_divisor_low};
  assign pnxt = s.pacc + 6'h02;
  assign plim = {1'b0, psc} + 6'h01;
  assign ptick = (psc != 5'h00) & (pnxt >= plim);
  assign stick = ptick & (s.dcnt >= div);

  // frame format decode
  assign chr = s.frame_select[`UMB_F_CHAR];
  assign nine = chr[1];
  assign par_on = s.frame_select[`UMB_F_PARITY] & ~nine & ~s.mode_select_one[`UMB_M_ATN];
  assign atn_act = s.mode_select_one[`UMB_M_ATN] & nine;
  assign rin = (chr == `UMB_CHLB) ? s.txd : rxd_i;
  assign v = (s.rsmp[1] & s.rsmp[0]) | (s.rsmp[1] & rin) | (s.rsmp[0] & rin);
  assign dlv = stick & (s.rxs == R_STOP) & (s.rsub == `UMB_SMP_C);
  assign xmip = (s.txs != T_IDLE) | ~s.tx_empty_flag;

  // data bit count and received character layout
  always_comb begin
    nlast = 4'h8;
    rbyte = s.rx_shift_reg[7:0];
    rb9 = s.rx_shift_reg[8];
    case (chr)
      `UMB_CH7: begin
        nlast = 4'h6;
        rbyte = {1'b0, s.rx_shift_reg[8:2]};
        rb9 = 1'b0;
      end
      `UMB_CH8: begin
        nlast = 4'h7;
        rbyte = s.rx_shift_reg[8:1];
        rb9 = 1'b0;
      end
      default: begin
        nlast = 4'h8;
        rbyte = s.rx_shift_reg[7:0];
        rb9 = s.rx_shift_reg[8];
      end
    endcase
  end

  // transmit line level for the present state
  always_comb begin
    case (s.txs)
      T_START: line = 1'b0;
      T_DATA:  line = s.tx_shift_reg[0];
      T_PAR:   line = s.tpar;
      default: line = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    n = s;
    n.ack = acc;
    // register reads; read-side clears come first so later sets win
    if (rd) begin
      case (ix)
        `UMB_IX_TXB: n.rdat = {24'h000000, s.tx_data_buffer};
        `UMB_IX_RXB: begin
          n.rdat = {24'h000000, s.rx_data_buffer};
          n.rx_full_flag = 1'b0;
        end
        `UMB_IX_ICT: begin
          n.rdat = {25'h0000000, s.cts_change_flag, s.rx_full_flag, s.tx_empty_flag, s.interrupt_control};
          n.cts_change_flag = 1'b0;
        end
        `UMB_IX_STA: begin
          n.rdat = {25'h0000000, xmip, s.rx_ninth_bit, s.bkd, s.error_summary_flag, s.doe, s.fe, s.pe};
          n.pe = 1'b0;
          n.fe = 1'b0;
          n.doe = 1'b0;
          n.bkd = 1'b0;
          n.error_summary_flag = 1'b0;
        end
        `UMB_IX_FRS: n.rdat = {24'h000000, s.frame_select};
        `UMB_IX_MD1: n.rdat = {24'h000000, s.mode_select_one};
        `UMB_IX_BDL: n.rdat = {24'h000000, s.baud_divisor_low};
        `UMB_IX_PSR: n.rdat = {24'h000000, s.baud_prescaler};
        `UMB_IX_OVR: n.rdat = {24'h000000, s.oversample_rate};
        `UMB_IX_MD2: n.rdat = {24'h000000, s.mode_select_two};
        `UMB_IX_SPS: n.rdat = {24'h000000, s.sample_position};
        default:     n.rdat = 32'h00000000;
      endcase
    end
    // register writes
    if (wr) begin
      case (ix)
        `UMB_IX_TXB: begin
          n.tx_data_buffer = wb_i.dat[7:0];
          n.tx_empty_flag = 1'b0;
        end
        `UMB_IX_ICT: n.interrupt_control = wb_i.dat[3:0];
        `UMB_IX_FRS: n.frame_select = wb_i.dat[7:0] & `UMB_F_MASK;
        `UMB_IX_MD1: n.mode_select_one = wb_i.dat[7:0];
        `UMB_IX_BDL: n.baud_divisor_low = wb_i.dat[7:0];
        `UMB_IX_PSR: n.baud_prescaler = wb_i.dat[7:0];
        `UMB_IX_OVR: n.oversample_rate = wb_i.dat[7:0];
        `UMB_IX_MD2: n.mode_select_two = wb_i.dat[7:0];
        `UMB_IX_SPS: n.sample_position = wb_i.dat[7:0];
        default: n.rdat = s.rdat;
      endcase
    end
    // baud chain advances only while a prescaler code is set
    if (psc != 5'h00) begin
      n.pacc = ptick ? (pnxt - plim) : pnxt;
      if (ptick) begin
        n.dcnt = (s.dcnt >= div) ? 11'h000 : (s.dcnt + 11'h001);
      end
    end else begin
      n.pacc = 6'h00; // a stopped clock restarts the half-step phase cleanly
    end
    // transmitter; a frame starts on a baud tick so the start bit is a full bit time
    if (s.txs == T_IDLE) begin
      if (stick & ~s.tx_empty_flag & ~wr_txb & ~(s.mode_select_one[`UMB_M_FCE] & cts_n_i)) begin
        n.tx_shift_reg = {s.frame_select[`UMB_F_XB9] & nine, s.tx_data_buffer};
        n.tpar = par_f({(chr != `UMB_CH7) & s.tx_data_buffer[7], s.tx_data_buffer[6:0]},
                       s.frame_select[`UMB_F_PSEL]);
        n.tx_empty_flag = 1'b1;
        n.txs = T_START;
        n.tsub = 4'h0;
      end
    end else if (stick) begin
      n.tsub = s.tsub + 4'h1;
      if (s.tsub == `UMB_SUB_LAST) begin
        case (s.txs)
          T_START: begin
            n.txs = T_DATA;
            n.tbit = 4'h0;
          end
          T_DATA: begin
            n.tx_shift_reg = s.tx_shift_reg >> 1;
            n.tbit = s.tbit + 4'h1;
            if (s.tbit == nlast) begin
              n.tbit = 4'h0;
              n.txs = par_on ? T_PAR : T_STOP;
            end
          end
          T_PAR: n.txs = T_STOP;
          T_STOP: begin
            n.tbit = s.tbit + 4'h1;
            if (s.tbit == {3'h0, s.frame_select[`UMB_F_STP]}) begin
              n.txs = T_IDLE;
            end
          end
          default: n.txs = T_IDLE;
        endcase
      end
    end
    n.txd = ~s.mode_select_one[`UMB_M_BRK] & line;
    // receiver, driven by the sixteen-per-bit tick
    if (stick) begin
      if (s.rxs == R_IDLE) begin
        if (~rin) begin
          n.rxs = R_START;
          n.rsub = 4'h1;
        end
      end else if (s.rxs == R_BRK) begin
        if (rin) begin
          n.rxs = R_IDLE;
        end else if (s.brkc != `UMB_BRK_TICKS) begin
          n.brkc = s.brkc + 9'h001;
          if (s.brkc == (`UMB_BRK_TICKS - 9'h001)) begin
            n.bkd = 1'b1;
            n.error_summary_flag = 1'b1;
          end
        end
      end else begin
        n.rsub = s.rsub + 4'h1;
        if ((s.rsub == `UMB_SMP_A) || (s.rsub == `UMB_SMP_B)) begin
          n.rsmp = {s.rsmp[0], rin};
        end
        if (s.rsub == `UMB_SMP_C) begin
          case (s.rxs)
            R_START: begin
              n.rxs = v ? R_IDLE : R_DATA;
              n.rbit = 4'h0;
            end
            R_DATA: begin
              n.rx_shift_reg = {v, s.rx_shift_reg[8:1]};
              n.rbit = s.rbit + 4'h1;
              if (s.rbit == nlast) begin
                n.rxs = par_on ? R_PAR : R_STOP;
              end
            end
            R_PAR: begin
              n.rpar = v;
              n.rxs = R_STOP;
            end
            R_STOP: begin
              n.rxs = v ? R_IDLE : R_BRK;
              n.brkc = 9'h000;
              if (~(atn_act & ~rb9)) begin
                n.rx_data_buffer = rbyte;
                n.rx_ninth_bit = rb9;
                n.rx_full_flag = 1'b1;
                if (s.rx_full_flag & ~rd_rxb) begin
                  n.doe = 1'b1;
                  n.error_summary_flag = 1'b1;
                end
                if (~v) begin
                  n.fe = 1'b1;
                  n.error_summary_flag = 1'b1;
                end
                if (par_on & (s.rpar != par_f(rbyte, s.frame_select[`UMB_F_PSEL]))) begin
                  n.pe = 1'b1;
                  n.error_summary_flag = 1'b1;
                end
                if (atn_act & ~wr_md1) begin
                  n.mode_select_one[`UMB_M_ATN] = 1'b0;
                end
              end
            end
            default: n.rxs = R_IDLE;
          endcase
        end
      end
    end
    // clear-to-send change and ready-to-send level
    n.cts_q = cts_n_i;
    if (cts_n_i != s.cts_q) begin
      n.cts_change_flag = 1'b1;
    end
    n.rts_n = ~n.mode_select_one[`UMB_M_RTS];
    // interrupt levels and dma pulses
    n.irq.tx = n.tx_empty_flag & n.interrupt_control[`UMB_I_ETI] & ~n.mode_select_one[`UMB_M_ETD];
    n.irq.rx = n.rx_full_flag & n.interrupt_control[`UMB_I_ERI] & ~n.mode_select_one[`UMB_M_ERD];
    n.irq.err = n.error_summary_flag & n.interrupt_control[`UMB_I_EEI];
    n.irq.flow = n.cts_change_flag & n.interrupt_control[`UMB_I_EFC];
    n.dma.tx = n.tx_empty_flag & ~s.tx_empty_flag & n.mode_select_one[`UMB_M_ETD];
    n.dma.rx = n.rx_full_flag & ~s.rx_full_flag & n.mode_select_one[`UMB_M_ERD];
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.tx_empty_flag <= `UMB_RST_TXE;
      s.txd <= `UMB_RST_LINE;
      s.rts_n <= `UMB_RST_LINE;
      s.cts_q <= `UMB_RST_LINE;
    end else if (ce_i) begin
      s <= n;
    end
  end

  // outputs
  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.rdat;
  assign txd_o = s.txd;
  assign rts_n_o = s.rts_n;
  assign irq_o = s.irq;
  assign dma_o = s.dma;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_tx_irq;
    $past(ce_i) |-> s.irq.tx == (s.tx_empty_flag & s.interrupt_control[`UMB_I_ETI] & ~s.mode_select_one[`UMB_M_ETD]);
  endproperty
  a_tx_irq: assert property (p_tx_irq)
    else $error("tx irq does not follow flag and enable");

  property p_rx_irq;
    $past(ce_i) |-> s.irq.rx == (s.rx_full_flag & s.interrupt_control[`UMB_I_ERI] & ~s.mode_select_one[`UMB_M_ERD]);
  endproperty
  a_rx_irq: assert property (p_rx_irq)
    else $error("rx irq does not follow flag and enable");

  property p_err_clr;
    ce_i && rd && (ix == `UMB_IX_STA) && !stick |=> !s.error_summary_flag && !s.irq.err;
  endproperty
  a_err_clr: assert property (p_err_clr)
    else $error("status read left error summary set");

  property p_flow_clr;
    ce_i && rd && (ix == `UMB_IX_ICT) && (cts_n_i == s.cts_q) |=> !s.cts_change_flag && !s.irq.flow;
  endproperty
  a_flow_clr: assert property (p_flow_clr)
    else $error("control read left cts change set");

  property p_tx_dma;
    s.dma.tx && ce_i |-> s.tx_empty_flag && !$past(s.tx_empty_flag) ##1 !s.dma.tx;
  endproperty
  a_tx_dma: assert property (p_tx_dma)
    else $error("tx dma request not a single rising pulse");

  property p_brk;
    $past(ce_i) && $past(s.mode_select_one[`UMB_M_BRK]) |-> !s.txd;
  endproperty
  a_brk: assert property (p_brk)
    else $error("break set but transmit line high");

  sequence s_addr_in;
    ce_i && dlv && atn_act && rb9 && !wr_md1;
  endsequence
  sequence s_woke;
    !s.mode_select_one[`UMB_M_ATN] && s.rx_full_flag && s.rx_ninth_bit;
  endsequence
  property p_atn;
    s_addr_in |=> s_woke;
  endproperty
  a_atn: assert property (p_atn)
    else $error("address character did not end wake mode");

  property p_discard;
    ce_i && dlv && atn_act && !rb9 |=> $stable(s.rx_data_buffer) && s.mode_select_one[`UMB_M_ATN];
  endproperty
  a_discard: assert property (p_discard)
    else $error("data character taken in wake mode");

  property p_psc_off;
    (psc == 5'h00) |-> !stick ##1 (!ce_i || $stable(s.dcnt));
  endproperty
  a_psc_off: assert property (p_psc_off)
    else $error("baud tick with prescaler stopped");

  sequence s_two_ticks;
    ce_i && (psc == 5'h02) && ptick ##1 ce_i && (psc == 5'h02) && ptick;
  endsequence
  property p_psc_half;
    s_two_ticks |=> (psc != 5'h02) || !ptick;
  endproperty
  a_psc_half: assert property (p_psc_half)
    else $error("factor 1.5 gave three ticks in a row");

  property p_loop;
    ce_i && (chr == `UMB_CHLB) && stick && (s.rxs == R_IDLE) && !s.txd |=> (s.rxs == R_START);
  endproperty
  a_loop: assert property (p_loop)
    else $error("loopback receiver did not see the transmit start");
endmodule

// ==== umb_peer.sv ====
// serial peer model: drives the uart receive line and captures its transmit line
module umb_peer (
  input  wire logic        clk_i,
  input  wire logic        txd_i,
  input  wire logic [15:0] bit_clks_i,
  output logic             rxd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // line idles high between frames
  initial rxd_o = 1'b1;
  // start bit, then n bits lsb first; caller supplies ninth bit and stop ones
  task automatic send(input logic [11:0] bits, input int n);
    rxd_o <= 1'b0;
    repeat (bit_clks_i) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      rxd_o <= bits[i];
      repeat (bit_clks_i) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
    @(posedge clk_i);
  endtask
  // wait for a start edge, then sample n bits at mid-bit
  task automatic recv(input int n, output logic [11:0] bits);
    int k;
    bits = '0;
    k = 0;
    while (txd_i !== 1'b0 && k < 20000) begin
      @(posedge clk_i);
      k++;
    end
    repeat (bit_clks_i / 2) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      repeat (bit_clks_i) @(posedge clk_i);
      bits[i] = txd_i;
    end
  endtask
  // line held low past the stop bit, as a break would
  task automatic hold_low(input int clks);
    rxd_o <= 1'b0;
    repeat (clks) @(posedge clk_i);
    rxd_o <= 1'b1;
    @(posedge clk_i);
  endtask
endmodule

// ==== umb_uart_tb.sv ====
// self-checking bench for the uart: registers, baud, frames, wake, dma, irq, break
`include "umb_map.svh"
module umb_uart_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import umb_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cts_n_i = 1'b1;
  umb_wb_type  wb = '0;
  logic        wb_ack_o, rxd_i, txd_o, rts_n_o;
  logic [31:0] wb_dat_o;
  umb_irq_type irq_o;
  umb_dma_type dma_o;
  logic [15:0] bit_clks = 16'h0010;
  logic [7:0]  v;
  logic [11:0] fr;
  int          failures = 0;
  int          check_count = 0;
  int          dtx_n = 0;
  int          drx_n = 0;
  ////////////////////////////////////////////////////////////////////////////////
  always #5 clk_i = ~clk_i;
  umb_uart DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_i(wb), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .rxd_i(rxd_i), .cts_n_i(cts_n_i), .txd_o(txd_o), .rts_n_o(rts_n_o),
    .irq_o(irq_o), .dma_o(dma_o));
  umb_peer peer (.clk_i(clk_i), .txd_i(txd_o), .bit_clks_i(bit_clks), .rxd_o(rxd_i));
  // dma pulse counters
  always @(posedge clk_i) begin
    if (dma_o.tx === 1'b1) dtx_n <= dtx_n + 1;
    if (dma_o.rx === 1'b1) drx_n <= drx_n + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one classic cycle: hold until ack is sampled, then release for a cycle
  task automatic bus(input logic [23:0] ix, input logic we, input logic [7:0] d);
    int n;
    n = 0;
    wb.cyc <= 1'b1;
    wb.stb <= 1'b1;
    wb.we <= we;
    wb.adr <= {ix, 2'b00};
    wb.sel <= 4'h1;
    wb.dat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 100);
    if (wb_ack_o !== 1'b1) failures++;
    v = wb_dat_o[7:0];
    wb.cyc <= 1'b0;
    wb.stb <= 1'b0;
    wb.we <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [23:0] ix, input logic [7:0] d);
    bus(ix, 1'b1, d);
  endtask
  task automatic rchk(input string nm, input logic [23:0] ix, input logic [7:0] m, input logic [7:0] e);
    bus(ix, 1'b0, 8'h00);
    chk(nm, {24'h000000, v & m}, {24'h000000, e});
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rchk("frame_select", `UMB_IX_FRS, 8'hFF, 8'h00);
    rchk("interrupt_control", `UMB_IX_ICT, 8'hFF, 8'h10);
    rchk("line_status", `UMB_IX_STA, 8'hFF, 8'h00);
    rchk("baud_prescaler", `UMB_IX_PSR, 8'hFF, 8'h00);
    wr(`UMB_IX_OVR, 8'h3C);
    rchk("oversample_rate", `UMB_IX_OVR, 8'hFF, 8'h3C);
    wr(`UMB_IX_STA, 8'hFF);
    rchk("status_write", `UMB_IX_STA, 8'hFF, 8'h00);
    rchk("unmapped", 24'hFFFE56, 8'hFF, 8'h00);
    wr(`UMB_IX_MD1, 8'h10);
    chk("rts_n", rts_n_o, 32'h0);
    wr(`UMB_IX_MD1, 8'h00);
  endtask
  // start-bit width of an all-ones byte for several prescaler and divisor settings
  task automatic t_baud();
    logic [7:0] ps [4] = '{8'h08, 8'h10, 8'hF8, 8'h08};
    logic [7:0] dl [4] = '{8'h00, 8'h00, 8'h00, 8'h02};
    int         ex [4] = '{16, 24, 256, 48};
    int         k;
    int         n;
    for (int i = 0; i < 4; i++) begin
      wr(`UMB_IX_PSR, 8'h00);
      wr(`UMB_IX_BDL, dl[i]);
      wr(`UMB_IX_PSR, ps[i]);
      wr(`UMB_IX_TXB, 8'hFF);
      k = 0;
      n = 0;
      while (txd_o !== 1'b0 && k < 1000) begin
        @(posedge clk_i);
        k++;
      end
      while (txd_o === 1'b0 && n < 1000) begin
        @(posedge clk_i);
        n++;
      end
      chk("bit_width", n, ex[i]);
      tk(ex[i] * 11);
    end
    wr(`UMB_IX_PSR, 8'h00);
    wr(`UMB_IX_BDL, 8'h00);
    wr(`UMB_IX_TXB, 8'h00);
    tk(300);
    chk("power_down_txd", txd_o, 32'h1);
    wr(`UMB_IX_PSR, 8'h08);
    peer.recv(10, fr);
    chk("resumed_frame", fr, 32'h300);
  endtask
  // every parity code with 7-bit, then 8-bit parity and 9-bit frames
  task automatic t_frames();
    logic [7:0]  fs [6] = '{8'h41, 8'h51, 8'h61, 8'h71, 8'h50, 8'h4A};
    logic [7:0]  dt [6] = '{8'h35, 8'h35, 8'h35, 8'h35, 8'hA7, 8'h3D};
    int          nb [6] = '{9, 9, 9, 9, 10, 10};
    logic [11:0] ex [6] = '{12'h1B5, 12'h135, 12'h1B5, 12'h135, 12'h3A7, 12'h33D};
    for (int i = 0; i < 6; i++) begin
      wr(`UMB_IX_FRS, fs[i]);
      wr(`UMB_IX_TXB, dt[i]);
      peer.recv(nb[i], fr);
      chk("tx_frame", fr, ex[i]);
      tk(16);
    end
  endtask
  task automatic t_wake();
    wr(`UMB_IX_FRS, 8'h02);
    wr(`UMB_IX_ICT, 8'h02);
    wr(`UMB_IX_MD1, 8'h02);
    peer.send(12'h233, 10);
    tk(4);
    rchk("wake_drop", `UMB_IX_ICT, 8'h20, 8'h00);
    peer.send(12'h3C4, 10);
    tk(4);
    chk("rx_irq", irq_o.rx, 32'h1);
    rchk("wake_clear", `UMB_IX_MD1, 8'hFF, 8'h00);
    rchk("rx_ninth", `UMB_IX_STA, 8'h20, 8'h20);
    rchk("addr_char", `UMB_IX_RXB, 8'hFF, 8'hC4);
    tk(2);
    chk("rx_irq_off", irq_o.rx, 32'h0);
    peer.send(12'h255, 10);
    rchk("data_after", `UMB_IX_RXB, 8'hFF, 8'h55);
  endtask
  task automatic t_dma();
    int n0;
    wr(`UMB_IX_FRS, 8'h00);
    wr(`UMB_IX_ICT, 8'h01);
    tk(2);
    chk("tx_irq", irq_o.tx, 32'h1);
    wr(`UMB_IX_ICT, 8'h00);
    tk(2);
    chk("tx_irq_mask", irq_o.tx, 32'h0);
    wr(`UMB_IX_ICT, 8'h03);
    wr(`UMB_IX_MD1, 8'h84);
    tk(2);
    chk("tx_irq_dma", irq_o.tx, 32'h0);
    n0 = dtx_n;
    wr(`UMB_IX_TXB, 8'h5A);
    peer.recv(10, fr);
    chk("dma_frame", fr, 32'h35A);
    chk("tx_dma_pulses", dtx_n - n0, 32'h1);
    n0 = drx_n;
    peer.send(12'h3E1, 10);
    tk(4);
    chk("rx_dma_pulses", drx_n - n0, 32'h1);
    chk("rx_irq_dma", irq_o.rx, 32'h0);
    rchk("rx_dma_data", `UMB_IX_RXB, 8'hFF, 8'hE1);
    wr(`UMB_IX_MD1, 8'h00);
    wr(`UMB_IX_ICT, 8'h00);
  endtask
  task automatic t_break();
    wr(`UMB_IX_MD1, 8'h20);
    chk("break_low", txd_o, 32'h0);
    tk(200);
    chk("break_held", txd_o, 32'h0);
    wr(`UMB_IX_MD1, 8'h00);
    chk("break_end", txd_o, 32'h1);
    wr(`UMB_IX_ICT, 8'h04);
    peer.hold_low(16 * 22);
    tk(4);
    chk("err_irq", irq_o.err, 32'h1);
    rchk("break_detect", `UMB_IX_STA, 8'h1A, 8'h1A);
    tk(2);
    chk("err_irq_off", irq_o.err, 32'h0);
    rchk("status_cleared", `UMB_IX_STA, 8'h1F, 8'h00);
    rchk("break_char", `UMB_IX_RXB, 8'hFF, 8'h00);
  endtask
  task automatic t_flow();
    wr(`UMB_IX_ICT, 8'h08);
    cts_n_i <= 1'b0;
    tk(3);
    chk("flow_irq", irq_o.flow, 32'h1);
    rchk("cts_change", `UMB_IX_ICT, 8'h40, 8'h40);
    tk(2);
    chk("flow_irq_off", irq_o.flow, 32'h0);
    rchk("cts_cleared", `UMB_IX_ICT, 8'h40, 8'h00);
    cts_n_i <= 1'b1;
    wr(`UMB_IX_MD1, 8'h08);
    wr(`UMB_IX_TXB, 8'h11);
    tk(40);
    chk("flow_hold", txd_o, 32'h1);
    cts_n_i <= 1'b0;
    peer.recv(10, fr);
    chk("flow_frame", fr, 32'h311);
    wr(`UMB_IX_MD1, 8'h00);
  endtask
  task automatic t_loop();
    wr(`UMB_IX_FRS, 8'h4B);
    wr(`UMB_IX_TXB, 8'h96);
    tk(240);
    rchk("loop_full", `UMB_IX_ICT, 8'h20, 8'h20);
    rchk("loop_ninth", `UMB_IX_STA, 8'h21, 8'h20);
    rchk("loop_data", `UMB_IX_RXB, 8'hFF, 8'h96);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence after reset
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_baud();
    t_frames();
    t_wake();
    t_dma();
    t_break();
    t_flow();
    t_loop();
    finish_test();
  end
  // watchdog against a hang
  initial begin
    repeat (40000) @(posedge clk_i);
    failures++;
    finish_test();
  end
endmodule
